/* File: verilog/cpp_pkg.sv */
// Shared constants and types of the clock prescaler and power control block
package cpp_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] CPP_OFF_CLKCS = 8'h00;
  localparam logic [7:0] CPP_OFF_SYS1 = 8'h04;
  localparam logic [7:0] CPP_OFF_SYS2 = 8'h08;
  localparam logic [7:0] CPP_OFF_TRIM = 8'h0C;
  localparam logic [7:0] CPP_OFF_MSTBY = 8'h10;
  localparam logic [7:0] CPP_OFF_SLEEP = 8'h14;
  localparam logic [7:0] CPP_OFF_MODE = 8'h18;

  // Field positions in clock_control_status
  localparam int CPP_CK_PINF_LSB = 6;
  localparam int CPP_CK_OSCSEL = 4;
  localparam int CPP_CK_IE = 3;
  localparam int CPP_CK_IF = 2;
  localparam int CPP_CK_RSV1 = 1;
  localparam int CPP_CK_STA = 0;

  // Field positions in system_control_one and system_control_two
  localparam int CPP_S1_STBY_SEL = 7;
  localparam int CPP_S2_SMSEL = 7;
  localparam int CPP_S2_LSON = 6;
  localparam int CPP_S2_MA_LSB = 2;
  localparam int CPP_S2_SA_LSB = 0;

  // Reset values
  localparam logic [7:0] CPP_SYS1_RST = 8'h00;
  localparam logic [7:0] CPP_SYS2_RST = 8'h00;
  localparam logic [7:0] CPP_TRIM_RST = 8'h00;
  localparam logic [12:0] CPP_PRESC_S_RST = 13'h0000;
  localparam logic [4:0] CPP_PRESC_W_RST = 5'h00;

  // Counter widths and timing counts
  localparam int CPP_PRESC_S_W = 13;
  localparam int CPP_PRESC_W_W = 5;
  localparam int CPP_SWITCH_WAIT = 8192;
  localparam logic [5:0] CPP_SUB_DIV4_TC = 6'h03;

  // Power modes
  typedef enum logic [2:0] {
    CPP_ACTIVE = 3'b000,
    CPP_SLEEP = 3'b001,
    CPP_SUBACTIVE = 3'b010,
    CPP_SUBSLEEP = 3'b011,
    CPP_STANDBY = 3'b100
  } cpp_mode_t;

  // Clock enable pulses handed to the rest of the chip
  typedef struct packed {
    logic cpu;
    logic periph;
    logic sub_time_base;
  } cpp_clk_en_t;

  // Terminal count of the active-mode divider from its select code
  function automatic logic [5:0] cpp_ma_tc(input logic [2:0] ma);
    logic [5:0] tc;
    tc = 6'h00;
    case (ma)
      3'b100: tc = 6'h07;
      3'b101: tc = 6'h0F;
      3'b110: tc = 6'h1F;
      3'b111: tc = 6'h3F;
      default: tc = 6'h00;
    endcase
    return tc;
  endfunction : cpp_ma_tc

  // Terminal count of the subclock divider from its select code
  function automatic logic [5:0] cpp_sa_tc(input logic [1:0] sa);
    logic [5:0] tc;
    tc = 6'h01;
    case (sa)
      2'b00: tc = 6'h07;
      2'b01: tc = 6'h03;
      default: tc = 6'h01;
    endcase
    return tc;
  endfunction : cpp_sa_tc

endpackage : cpp_pkg

/* File: verilog/cpp_tick_div.sv */
`timescale 1ns/1ps
// Programmable divider that turns enabled cycles into one-cycle tick pulses
module cpp_tick_div
  import cpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic clr,
  input wire logic [5:0] term,
  output logic tick
);

  // Divider state
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } cpp_div_st_t;

  cpp_div_st_t st_reg;
  cpp_div_st_t st_next;

  // Count enabled cycles and pulse on the terminal count
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (clr)
    begin
      st_next.cnt = 6'h00;
    end
    else if (en)
    begin
      if (st_reg.cnt >= term)
      begin
        st_next.cnt = 6'h00;
        st_next.tick = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule : cpp_tick_div

/* File: verilog/cpp_clock_power.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module cpp_clock_power
  import cpp_pkg::*;
#(
  parameter int NUM_MOD = 16,
  parameter int SWITCH_WAIT = CPP_SWITCH_WAIT,
  parameter logic [7:0] TRIM_INIT = CPP_TRIM_RST
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subclk_pin,
  input wire logic wake_req,
  input wire logic rtc_time_base_sel,
  output cpp_clk_en_t clk_en,
  output logic [CPP_PRESC_S_W-1:0] presc_s_taps,
  output logic [CPP_PRESC_W_W-1:0] presc_w_taps,
  output logic [NUM_MOD-1:0] module_run,
  output logic rtc_run,
  output logic cpu_halt,
  output logic clock_source_status,
  output logic clock_switch_irq,
  output logic [1:0] osc_pin_func,
  output logic [7:0] oscillator_trim_data,
  output cpp_mode_t power_mode
);

  // Width of the switchover wait counter
  localparam int WAIT_W = $clog2(SWITCH_WAIT + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(SWITCH_WAIT - 1);

  // Whole state of the block
  typedef struct packed {
    logic [1:0] pin_func;                  // Oscillator pin function
    logic osc_sel;                         // Requested source, 1 external
    logic irq_en;                          // Clock switch interrupt enable
    logic irq_flag;                        // Clock switch interrupt flag
    logic flag_armed;                      // Flag was read as one
    logic src_ext;                         // Source actually in use
    logic switching;                       // Waiting for external settle
    logic [WAIT_W-1:0] wait_cnt;           // Settle wait counter
    logic [7:0] sys1;                      // system_control_one
    logic [7:0] sys2;                      // system_control_two
    logic [2:0] ma_eff;                    // Divider select in force
    logic [1:0] sa_eff;                    // Subclock select in force
    logic [7:0] trim;                      // Oscillator trim data
    logic [NUM_MOD-1:0] mstby;             // Module standby bits
    cpp_mode_t mode;                       // Power mode
    logic [CPP_PRESC_S_W-1:0] presc_s;     // System prescaler
    logic [CPP_PRESC_W_W-1:0] presc_w;     // Subclock prescaler
    logic sub_s1;                          // Subclock synchroniser stage 1
    logic sub_s2;                          // Subclock synchroniser stage 2
    logic sub_s3;                          // Edge detect history
    logic pready;                          // APB ready
    logic pslverr;                         // APB error
    logic [31:0] prdata;                   // APB read data
    cpp_clk_en_t clk_en;                   // Registered clock enables
    logic irq;                             // Registered interrupt request
    logic [NUM_MOD-1:0] mod_run;           // Registered module run
    logic rtc_run;                         // Registered RTC run
    logic cpu_halt;                        // Registered CPU halt
  } cpp_st_t;

  cpp_st_t st_reg;
  cpp_st_t st_next;

  // Divider ticks, subclock edge and system stop
  logic act_tick;
  logic w4_tick;
  logic sub_tick;
  logic sub_edge;
  logic sys_stop;

  // Rising edge of the synchronised subclock
  assign sub_edge = st_reg.sub_s2 & ~st_reg.sub_s3;
  // System clock generator stops in standby and subsleep
  assign sys_stop = (st_reg.mode == CPP_STANDBY) || (st_reg.mode == CPP_SUBSLEEP);

  cpp_tick_div u_act_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(1'b1),
    .clr(sys_stop),
    .term(cpp_ma_tc(st_reg.ma_eff)),
    .tick(act_tick)
  );

  cpp_tick_div u_w4_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(sub_edge),
    .clr(1'b0),
    .term(CPP_SUB_DIV4_TC),
    .tick(w4_tick)
  );

  cpp_tick_div u_sub_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(sub_edge),
    .clr(1'b0),
    .term(cpp_sa_tc(st_reg.sa_eff)),
    .tick(sub_tick)
  );

  // Read data of one register offset
  function automatic logic [31:0] rd_mux(input cpp_st_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      CPP_OFF_CLKCS:
      begin
        d[CPP_CK_PINF_LSB +: 2] = s.pin_func;
        d[CPP_CK_OSCSEL] = s.osc_sel;
        d[CPP_CK_IE] = s.irq_en;
        d[CPP_CK_IF] = s.irq_flag;
        d[CPP_CK_RSV1] = 1'b1;
        d[CPP_CK_STA] = s.src_ext;
      end
      CPP_OFF_SYS1: d[7:0] = s.sys1;
      CPP_OFF_SYS2: d[7:0] = s.sys2;
      CPP_OFF_TRIM: d[7:0] = s.trim;
      CPP_OFF_MSTBY: d[NUM_MOD-1:0] = s.mstby;
      CPP_OFF_MODE: d[2:0] = s.mode;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  // Whether an offset is mapped
  // prescalers have no offset
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == CPP_OFF_CLKCS) || (a == CPP_OFF_SYS1) || (a == CPP_OFF_SYS2) ||
           (a == CPP_OFF_TRIM) || (a == CPP_OFF_MSTBY) || (a == CPP_OFF_SLEEP) ||
           (a == CPP_OFF_MODE);
  endfunction : is_mapped

  // Next state of the whole block
  always_comb
  begin
    logic access;
    logic done;
    logic wr;
    logic rd;
    logic sleep_exec;
    logic periph_tick;
    access = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    sleep_exec = 1'b0;
    periph_tick = 1'b0;
    st_next = st_reg;

    // Subclock pin synchroniser and edge history
    st_next.sub_s1 = subclk_pin;
    st_next.sub_s2 = st_reg.sub_s1;
    st_next.sub_s3 = st_reg.sub_s2;

    // APB: one wait cycle, data and error registered with ready
    access = psel & penable;
    done = access & st_reg.pready;
    wr = done & pwrite & is_mapped(paddr);
    rd = done & ~pwrite;
    st_next.pready = access & ~st_reg.pready;
    st_next.pslverr = access & ~st_reg.pready & ~is_mapped(paddr);
    if (access && !st_reg.pready)
    begin
      st_next.prdata = pwrite ? 32'h0000_0000 : rd_mux(st_reg, paddr);
    end

    // reading the flag as one arms its clear
    if (rd && paddr == CPP_OFF_CLKCS && st_reg.irq_flag)
    begin
      st_next.flag_armed = 1'b1;
    end

    // Register writes
    if (wr)
    begin
      case (paddr)
        CPP_OFF_CLKCS:
        begin
          st_next.pin_func = pwdata[CPP_CK_PINF_LSB +: 2];
          st_next.irq_en = pwdata[CPP_CK_IE];
          st_next.flag_armed = 1'b0;
          if (!pwdata[CPP_CK_IF] && st_reg.flag_armed)
          begin
            st_next.irq_flag = 1'b0;
          end
          // select external only while flag is clear
          if (pwdata[CPP_CK_OSCSEL] && !st_reg.irq_flag)
          begin
            st_next.osc_sel = 1'b1;
            if (!st_reg.src_ext && !st_reg.switching)
            begin
              st_next.switching = 1'b1;
              st_next.wait_cnt = '0;
            end
          end
          else if (!pwdata[CPP_CK_OSCSEL])
          begin
            st_next.osc_sel = 1'b0;
            st_next.switching = 1'b0;
          end
        end
        CPP_OFF_SYS1: st_next.sys1 = pwdata[7:0];
        CPP_OFF_SYS2: st_next.sys2 = pwdata[7:0];
        CPP_OFF_TRIM: st_next.trim = pwdata[7:0];
        CPP_OFF_MSTBY: st_next.mstby = pwdata[NUM_MOD-1:0];
        CPP_OFF_SLEEP: sleep_exec = 1'b1;
        default: st_next.mode = st_reg.mode;
      endcase
    end

    // status follows only after the settle wait ends
    if (st_reg.switching && act_tick)
    begin
      if (st_reg.wait_cnt == WAIT_LAST)
      begin
        st_next.src_ext = 1'b1;
        st_next.switching = 1'b0;
      end
      else
      begin
        st_next.wait_cnt = st_reg.wait_cnt + WAIT_W'(1);
      end
    end

    // flag set on leaving the external clock, set wins
    if (!st_reg.osc_sel && st_reg.src_ext)
    begin
      st_next.src_ext = 1'b0;
      st_next.irq_flag = 1'b1;
    end

    // Power mode machine
    case (st_reg.mode)
      CPP_ACTIVE, CPP_SUBACTIVE:
      begin
        if (sleep_exec)
        begin
          // new rates take effect on the sleep command
          st_next.ma_eff = st_reg.sys2[CPP_S2_MA_LSB +: 3];
          st_next.sa_eff = st_reg.sys2[CPP_S2_SA_LSB +: 2];
          // standby select, then subsleep select, then low-speed select decide the target mode
          if (st_reg.sys1[CPP_S1_STBY_SEL])
          begin
            st_next.mode = CPP_STANDBY;
          end
          else if (st_reg.sys2[CPP_S2_SMSEL])
          begin
            st_next.mode = CPP_SUBSLEEP;
          end
          else if (st_reg.sys2[CPP_S2_LSON])
          begin
            st_next.mode = CPP_SUBACTIVE;
          end
          else
          begin
            st_next.mode = CPP_SLEEP;
          end
        end
      end
      CPP_SLEEP, CPP_SUBSLEEP, CPP_STANDBY:
      begin
        // Wake returns to the running mode chosen by low-speed select
        if (wake_req)
        begin
          st_next.mode = st_reg.sys2[CPP_S2_LSON] ? CPP_SUBACTIVE : CPP_ACTIVE;
        end
      end
      default: st_next.mode = CPP_ACTIVE;
    endcase

    // halt and clear in standby and subsleep
    if (sys_stop)
    begin
      st_next.presc_s = CPP_PRESC_S_RST;
    end
    // free-running count on the divided system clock
    else if (act_tick)
    begin
      st_next.presc_s = st_reg.presc_s + CPP_PRESC_S_W'(1);
    end

    // subclock prescaler runs in every mode while edges arrive
    if (w4_tick)
    begin
      st_next.presc_w = st_reg.presc_w + CPP_PRESC_W_W'(1);
    end

    // Clock enables per mode
    case (st_reg.mode)
      // active mode on the system clock
      CPP_ACTIVE:
      begin
        st_next.clk_en.cpu = act_tick;
        periph_tick = act_tick;
      end
      CPP_SLEEP:
      begin
        st_next.clk_en.cpu = 1'b0;
        periph_tick = act_tick;
      end
      CPP_SUBACTIVE:
      begin
        st_next.clk_en.cpu = sub_tick;
        periph_tick = sub_tick;
      end
      CPP_SUBSLEEP:
      begin
        st_next.clk_en.cpu = 1'b0;
        periph_tick = sub_tick;
      end
      default:
      begin
        st_next.clk_en.cpu = 1'b0;
        periph_tick = 1'b0;
      end
    endcase
    st_next.clk_en.periph = periph_tick;
    st_next.clk_en.sub_time_base = w4_tick;
    st_next.cpu_halt = (st_reg.mode != CPP_ACTIVE) && (st_reg.mode != CPP_SUBACTIVE);

    st_next.mod_run = (st_reg.mode == CPP_STANDBY) ? '0 : ~st_reg.mstby;
    // RTC in standby only with its time-base function
    if (st_reg.mode == CPP_STANDBY)
    begin
      st_next.rtc_run = rtc_time_base_sel & ~st_reg.mstby[0];
    end
    else
    begin
      st_next.rtc_run = ~st_reg.mstby[0];
    end

    // interrupt request from enable and flag
    st_next.irq = st_reg.irq_en & st_reg.irq_flag;
  end

  // State register; reset selects the internal oscillator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.src_ext <= 1'b0;
      st_reg.mode <= CPP_ACTIVE;
      st_reg.sys1 <= CPP_SYS1_RST;
      st_reg.sys2 <= CPP_SYS2_RST;
      // trim data back to its initial value
      st_reg.trim <= TRIM_INIT;
      st_reg.presc_s <= CPP_PRESC_S_RST;
      st_reg.presc_w <= CPP_PRESC_W_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign clk_en = st_reg.clk_en;
  // shared taps; each peripheral picks its own bit
  assign presc_s_taps = st_reg.presc_s;
  assign presc_w_taps = st_reg.presc_w;
  assign module_run = st_reg.mod_run;
  assign rtc_run = st_reg.rtc_run;
  assign cpu_halt = st_reg.cpu_halt;
  assign clock_source_status = st_reg.src_ext;
  assign clock_switch_irq = st_reg.irq;
  assign osc_pin_func = st_reg.pin_func;
  assign oscillator_trim_data = st_reg.trim;
  assign power_mode = st_reg.mode;

endmodule : cpp_clock_power

/* File: tb/cpp_clock_power_chk.sv */
`timescale 1ns/1ps
// Port-level checker of the clock and power control block
module cpp_clock_power_chk
  import cpp_pkg::*;
#(
  parameter int NUM_MOD = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cpp_clk_en_t clk_en,
  input wire logic [CPP_PRESC_S_W-1:0] presc_s_taps,
  input wire logic [CPP_PRESC_W_W-1:0] presc_w_taps,
  input wire logic [NUM_MOD-1:0] module_run,
  input wire logic cpu_halt,
  input wire logic clock_source_status,
  input wire logic [7:0] oscillator_trim_data,
  input wire cpp_mode_t power_mode
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed transfer and completed status read
  logic done;
  logic ck_rd;
  assign done = psel && penable && pready;
  assign ck_rd = done && !pwrite && (paddr == CPP_OFF_CLKCS);
  rsv_one_a: assert property (ck_rd |-> prdata[CPP_CK_RSV1])
    else $error("reserved status bit not one");
  sta_read_a: assert property (ck_rd |-> prdata[0] == $past(clock_source_status))
    else $error("source status read mismatch");
  no_counter_a: assert property (done && paddr > CPP_OFF_MODE |-> pslverr)
    else $error("unmapped access not refused");
  switch_wait_a: assert property ((done && pwrite && paddr == CPP_OFF_CLKCS
    && pwdata[CPP_CK_OSCSEL] && !clock_source_status) |-> ##1 (!clock_source_status)[*3])
    else $error("source status changed before switchover");
  presc_step_a: assert property ($changed(presc_s_taps) |->
    presc_s_taps == $past(presc_s_taps) + 13'h1 || presc_s_taps == 13'h0)
    else $error("system prescaler skipped");
  sub_step_a: assert property ($changed(presc_w_taps) |->
    presc_w_taps == $past(presc_w_taps) + 5'h1 || presc_w_taps == 5'h0)
    else $error("subclock prescaler skipped");
  presc_hold_a: assert property ((power_mode inside {CPP_STANDBY, CPP_SUBSLEEP})[*2]
    |-> presc_s_taps == 13'h0)
    else $error("system prescaler not held at zero");
  standby_halt_a: assert property ((power_mode == CPP_STANDBY)[*2] |->
    module_run == '0 && !clk_en.periph && !clk_en.cpu)
    else $error("activity in standby");
  sleep_halt_a: assert property ((power_mode == CPP_SLEEP)[*2] |-> cpu_halt && !clk_en.cpu)
    else $error("cpu running in sleep");
  trim_init_a: assert property ($rose(presetn) |-> oscillator_trim_data == CPP_TRIM_RST)
    else $error("trim data not initial after reset");
  // Main scenarios reached
  cov_standby: cover property (power_mode == CPP_STANDBY);
  cov_ext: cover property ($rose(clock_source_status));
  cov_err: cover property (done && pslverr);
endmodule : cpp_clock_power_chk

bind cpp_clock_power cpp_clock_power_chk #(.NUM_MOD(NUM_MOD)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clk_en(clk_en), .presc_s_taps(presc_s_taps), .presc_w_taps(presc_w_taps),
  .module_run(module_run), .cpu_halt(cpu_halt), .clock_source_status(clock_source_status),
  .oscillator_trim_data(oscillator_trim_data), .power_mode(power_mode)
);

/* File: tb/cpp_clock_power_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
// Self-checking bench driving APB and the mode inputs
module cpp_clock_power_tb
  import cpp_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic subclk_pin = 1'b0, wake_req = 1'b0, rtc_time_base_sel = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rtc_run, cpu_halt, clock_source_status, clock_switch_irq;
  cpp_clk_en_t clk_en;
  logic [12:0] presc_s_taps;
  logic [4:0] presc_w_taps;
  logic [15:0] module_run;
  logic [1:0] osc_pin_func;
  logic [7:0] oscillator_trim_data;
  cpp_mode_t power_mode;
  logic [3:0] sub_div = 4'h0;
  int n_errors = 0;
  int n_checks = 0;
  int np, nc, nt;
  logic [12:0] v;

  cpp_clock_power #(.SWITCH_WAIT(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .subclk_pin(subclk_pin), .wake_req(wake_req), .rtc_time_base_sel(rtc_time_base_sel),
    .clk_en(clk_en), .presc_s_taps(presc_s_taps), .presc_w_taps(presc_w_taps),
    .module_run(module_run), .rtc_run(rtc_run), .cpu_halt(cpu_halt),
    .clock_source_status(clock_source_status), .clock_switch_irq(clock_switch_irq),
    .osc_pin_func(osc_pin_func), .oscillator_trim_data(oscillator_trim_data),
    .power_mode(power_mode)
  );

  // 20 MHz clock
  always #25 pclk = ~pclk;
  // Fast stand-in watch clock, period 16 cycles
  always @(posedge pclk)
  begin
    sub_div <= sub_div + 4'h1;
    subclk_pin <= sub_div[3];
  end

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // Read and compare data and error response
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x, q)
    `CHK("pslverr", xe, e)
  endtask : rd

  // Issue the sleep command and check the mode entered
  task automatic enter(input cpp_mode_t m);
    wr(CPP_OFF_SLEEP, 32'h0);
    @(posedge pclk);
    `CHK("power_mode", m, power_mode)
  endtask : enter

  // Wake pulse back to active mode
  task automatic wake();
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("power_mode", CPP_ACTIVE, power_mode)
  endtask : wake

  // Count enable pulses over a span
  task automatic count(input int cyc);
    np = 0;
    nc = 0;
    nt = 0;
    repeat (cyc)
    begin
      @(posedge pclk);
      if (clk_en.periph === 1'b1)
        np++;
      if (clk_en.cpu === 1'b1)
        nc++;
      if (clk_en.sub_time_base === 1'b1)
        nt++;
    end
  endtask : count

  // Bounded wait for the source status
  task automatic wait_sta(input logic s);
    int n;
    n = 0;
    while (clock_source_status !== s && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("clock_source_status", s, clock_source_status)
  endtask : wait_sta

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial
  begin
    #(20000 * 50);
    n_errors++;
    report_and_stop();
  end

  // Test sequence
  initial
  begin
    do_reset();
    `CHK("clock_source_status", 1'b0, clock_source_status)
    rd(CPP_OFF_CLKCS, 32'h02, 1'b0, "clk_status");
    rd(CPP_OFF_SYS1, 32'h0, 1'b0, "sys1");
    rd(CPP_OFF_SYS2, 32'h0, 1'b0, "sys2");
    rd(CPP_OFF_MODE, 32'h0, 1'b0, "mode");
    rd(8'h1C, 32'h0, 1'b1, "unmapped");
    v = presc_s_taps;
    repeat (5) @(posedge pclk);
    `CHK("presc_s step", 13'h5, presc_s_taps - v)
    $display("test reset done");
    wr(CPP_OFF_CLKCS, 32'h10);
    `CHK("clock_source_status", 1'b0, clock_source_status)
    wait_sta(1'b1);
    rd(CPP_OFF_CLKCS, 32'h13, 1'b0, "clk_status");
    wr(CPP_OFF_CLKCS, 32'h00);
    wait_sta(1'b0);
    rd(CPP_OFF_CLKCS, 32'h06, 1'b0, "clk_status");
    `CHK("clock_switch_irq", 1'b0, clock_switch_irq)
    wr(CPP_OFF_CLKCS, 32'h0C);
    @(posedge pclk);
    `CHK("clock_switch_irq", 1'b1, clock_switch_irq)
    rd(CPP_OFF_CLKCS, 32'h0E, 1'b0, "clk_status");
    wr(CPP_OFF_CLKCS, 32'h08);
    @(posedge pclk);
    `CHK("clock_switch_irq", 1'b0, clock_switch_irq)
    rd(CPP_OFF_CLKCS, 32'h0A, 1'b0, "clk_status");
    $display("test switch done");
    wr(CPP_OFF_TRIM, 32'hA5);
    rd(CPP_OFF_TRIM, 32'hA5, 1'b0, "trim");
    wr(CPP_OFF_CLKCS, 32'h10);
    wait_sta(1'b1);
    do_reset();
    `CHK("clock_source_status", 1'b0, clock_source_status)
    `CHK("presc_w_taps", 5'h00, presc_w_taps)
    rd(CPP_OFF_TRIM, 32'h0, 1'b0, "trim");
    $display("test trim done");
    wr(CPP_OFF_SYS2, 32'h10);
    enter(CPP_SLEEP);
    count(64);
    `CHK("periph ticks", 8, np)
    `CHK("cpu ticks", 0, nc)
    `CHK("cpu_halt", 1'b1, cpu_halt)
    wake();
    wr(CPP_OFF_SYS1, 32'h80);
    enter(CPP_STANDBY);
    `CHK("presc_s_taps", 13'h0, presc_s_taps)
    `CHK("module_run", 16'h0, module_run)
    `CHK("rtc_run", 1'b0, rtc_run)
    rtc_time_base_sel <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("rtc_run", 1'b1, rtc_run)
    v = {8'h00, presc_w_taps};
    count(400);
    `CHK("presc_w moved", 1'b1, v[4:0] !== presc_w_taps)
    `CHK("time base ticks", 1'b1, nt > 0)
    `CHK("standby periph ticks", 0, np)
    rtc_time_base_sel <= 1'b0;
    wake();
    wr(CPP_OFF_SYS1, 32'h00);
    wr(CPP_OFF_SYS2, 32'h80);
    enter(CPP_SUBSLEEP);
    `CHK("presc_s_taps", 13'h0, presc_s_taps)
    `CHK("cpu_halt", 1'b1, cpu_halt)
    wake();
    wr(CPP_OFF_SYS2, 32'h40);
    enter(CPP_SUBACTIVE);
    count(320);
    `CHK("cpu ticks sub 8", 1'b1, nc >= 2 && nc <= 3)
    wr(CPP_OFF_SYS2, 32'h41);
    enter(CPP_SUBACTIVE);
    count(320);
    `CHK("cpu ticks sub 4", 1'b1, nc >= 4 && nc <= 6)
    wr(CPP_OFF_SYS2, 32'h00);
    enter(CPP_SLEEP);
    wake();
    wr(CPP_OFF_SYS2, 32'h1C);
    enter(CPP_SLEEP);
    count(160);
    `CHK("periph ticks div 64", 2, np)
    wake();
    $display("test modes done");
    wr(CPP_OFF_CLKCS, 32'hC0);
    `CHK("osc_pin_func", 2'b11, osc_pin_func)
    rd(CPP_OFF_CLKCS, 32'hC2, 1'b0, "clk_status");
    wr(CPP_OFF_MSTBY, 32'h3);
    @(posedge pclk);
    `CHK("module_run", 16'hFFFC, module_run)
    `CHK("rtc_run", 1'b0, rtc_run)
    $display("test module standby done");
    report_and_stop();
  end
endmodule : cpp_clock_power_tb
